/* lsi_host_model.sv */
// host processor model on the parallel register port of the status block
// assumes the block takes wr/rd strobes at a rising edge, read data one cycle later
`timescale 1ns/1ps
module lsi_host_model (
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  output lsi_pkg::lsi_port_t o_port
);
  initial o_port = '0;

  // ==========================================
  // bus cycles
  // address and data are scrambled once released so stale values never look valid
  task automatic release_port();
    o_port.wr <= 1'b0;
    o_port.rd <= 1'b0;
    o_port.addr <= ~o_port.addr;
    o_port.wdata <= ~o_port.wdata;
  endtask

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clock);
    o_port <= '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
    @(posedge i_clock);
    release_port();
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_clock);
    o_port <= '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge i_clock);
    release_port();
    #1;
    data = i_rdata;
  endtask

  // write-read-write so events landing between steps are not lost
  task automatic poll(input logic [7:0] mask, output logic [7:0] data);
    write_reg(lsi_pkg::ADDR_STATUS, mask);
    read_reg(lsi_pkg::ADDR_STATUS, data);
    write_reg(lsi_pkg::ADDR_STATUS, data & mask);
  endtask
endmodule

/* lsi_line_alarms.sv */
// unframed all ones and carrier loss detectors on the received bit stream
// assumes i_bit_en marks one received bit on the core clock
`timescale 1ns/1ps
module lsi_line_alarms #(
  parameter int unsigned UA1_WIN_CYC = lsi_pkg::UA1_T1_WIN_CYC
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_bit_en,
  input wire logic i_bit,
  input wire logic i_e1_mode,
  input wire logic i_long_los,
  output logic o_ua1_alarm,
  output logic o_rcl_alarm
);
  // ==========================================
  // unframed all ones
  logic [19:0] win_q;
  logic [2:0] zeros_q;
  logic ua1_q;
  logic zero_in;
  logic win_end;
  logic [3:0] zsum;
  assign zero_in = i_bit_en & ~i_bit;
  assign zsum = {1'b0, zeros_q} + {3'h0, zero_in};
  // e1 counts bits, t1 counts core cycles of the time window
  assign win_end = i_e1_mode ? (i_bit_en && win_q[8:0] == lsi_pkg::UA1_E1_WIN_LAST)
                             : (win_q == 20'(UA1_WIN_CYC - 1));
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      win_q <= 20'h00000;
    else if (win_end)
      win_q <= 20'h00000;
    else if (i_bit_en || !i_e1_mode)
      win_q <= win_q + 20'h00001;
  end
  always_ff @(posedge i_clock)
  begin
    if (i_srst || win_end)
      zeros_q <= 3'h0;
    else if (zero_in && zeros_q != 3'h7)
      zeros_q <= zeros_q + 3'h1;
  end
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      ua1_q <= 1'b0;
    else if (win_end && i_e1_mode)
    begin
      if (zsum < lsi_pkg::UA1_E1_ZEROS)
        ua1_q <= 1'b1;
      else if (zsum > lsi_pkg::UA1_E1_ZEROS)
        ua1_q <= 1'b0;
    end
    else if (win_end)
    begin
      if (zsum <= lsi_pkg::UA1_T1_SET_MAX)
        ua1_q <= 1'b1;
      else if (zsum >= lsi_pkg::UA1_T1_CLR_MIN)
        ua1_q <= 1'b0;
    end
  end
  assign o_ua1_alarm = ua1_q;
  // ==========================================
  // carrier loss: clear window opens at the first one seen
  lsi_pkg::lsi_rcl_state_t st_q;
  logic [11:0] run_q;
  logic [11:0] run_lim;
  logic [7:0] wcnt_q;
  logic [7:0] ones_q;
  logic [7:0] win_len;
  logic [7:0] ones_thr;
  assign run_lim = i_e1_mode
    ? (i_long_los ? lsi_pkg::RCL_E1_ZEROS_LONG : lsi_pkg::RCL_E1_ZEROS)
    : (i_long_los ? lsi_pkg::RCL_T1_ZEROS_LONG : lsi_pkg::RCL_T1_ZEROS);
  assign win_len = i_e1_mode ? lsi_pkg::RCL_E1_WIN : lsi_pkg::RCL_T1_WIN;
  assign ones_thr = i_e1_mode ? lsi_pkg::RCL_E1_ONES : lsi_pkg::RCL_T1_ONES;
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      run_q <= 12'h000;
    else if (i_bit_en)
      run_q <= i_bit ? 12'h000 : (run_q == 12'hfff ? run_q : run_q + 12'h001);
  end
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      st_q <= lsi_pkg::RCL_CLEAR;
      wcnt_q <= 8'h00;
      ones_q <= 8'h00;
    end
    else if (i_bit_en)
    begin
      case (st_q)
        lsi_pkg::RCL_CLEAR:
          if (!i_bit && run_q + 12'h001 == run_lim)
            st_q <= lsi_pkg::RCL_LOST;
        lsi_pkg::RCL_LOST:
          if (i_bit)
          begin
            st_q <= lsi_pkg::RCL_WINDOW;
            wcnt_q <= 8'h01;
            ones_q <= 8'h01;
          end
        lsi_pkg::RCL_WINDOW:
        begin
          wcnt_q <= wcnt_q + 8'h01;
          ones_q <= ones_q + {7'h00, i_bit};
          if (ones_q + {7'h00, i_bit} >= ones_thr)
            st_q <= lsi_pkg::RCL_CLEAR;
          else if (wcnt_q + 8'h01 >= win_len)
            st_q <= lsi_pkg::RCL_LOST;
        end
        default:
          st_q <= lsi_pkg::RCL_CLEAR;
      endcase
    end
  end
  assign o_rcl_alarm = st_q[0];

  chk_rcl_set_run: assert property (@(posedge i_clock) disable iff (i_srst)
    st_q == lsi_pkg::RCL_CLEAR && i_bit_en && !i_bit && run_q + 12'h001 == run_lim
    |=> o_rcl_alarm)
    else $error("carrier loss not raised at zero run limit");
  chk_rcl_clear_ones: assert property (@(posedge i_clock) disable iff (i_srst)
    st_q == lsi_pkg::RCL_WINDOW && i_bit_en && ones_q + {7'h00, i_bit} >= ones_thr
    |=> !o_rcl_alarm)
    else $error("carrier loss not cleared after enough ones");
  chk_ua1_e1_set: assert property (@(posedge i_clock) disable iff (i_srst)
    win_end && i_e1_mode && zsum < lsi_pkg::UA1_E1_ZEROS |=> o_ua1_alarm)
    else $error("all ones alarm not set in e1 window");
endmodule

/* lsi_pkg.sv */
// shared constants and carriers of the line status and interrupt block
// assumes a 200 MHz core clock; line bits arrive as enables on that clock
package lsi_pkg;
  // ==========================================
  // register map
  localparam logic [7:0] ADDR_STATUS = 8'h06;
  localparam logic [7:0] ADDR_MASK = 8'h07;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  // status bit positions
  localparam int BIT_LOOP_UP = 7;
  localparam int BIT_LOOP_DOWN = 6;
  localparam int BIT_TRANSMIT_CLOCK_IN_LOST = 5;
  localparam int BIT_ALL_ONES = 4;
  localparam int BIT_CARRIER = 3;
  localparam int BIT_CUR_LIMIT = 2;
  localparam int BIT_TX_OPEN = 1;
  localparam int BIT_PRBS = 0;
  localparam logic [7:0] LATCHED_BITS = 8'hd8;
  localparam logic [7:0] STICKY_BITS = 8'h18;
  localparam logic [7:0] COS_BITS = 8'h38;
  // ==========================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int TRANSMIT_CLOCK_LOST_NS = 5000;
  localparam int TRANSMIT_CLOCK_LOST_CYC = TRANSMIT_CLOCK_LOST_NS * CLK_MHZ / 1000;
  localparam int UA1_T1_WIN_US = 3000;
  localparam int UA1_T1_WIN_CYC = UA1_T1_WIN_US * CLK_MHZ;
  // ==========================================
  // alarm criteria
  localparam logic [8:0] UA1_E1_WIN_LAST = 9'h1ff;
  localparam logic [3:0] UA1_E1_ZEROS = 4'h2;
  localparam logic [3:0] UA1_T1_SET_MAX = 4'h5;
  localparam logic [3:0] UA1_T1_CLR_MIN = 4'h6;
  localparam logic [11:0] RCL_E1_ZEROS = 12'h0ff;
  localparam logic [11:0] RCL_E1_ZEROS_LONG = 12'h800;
  localparam logic [11:0] RCL_T1_ZEROS = 12'h0c0;
  localparam logic [11:0] RCL_T1_ZEROS_LONG = 12'h608;
  localparam logic [7:0] RCL_E1_WIN = 8'hff;
  localparam logic [7:0] RCL_E1_ONES = 8'h20;
  localparam logic [7:0] RCL_T1_WIN = 8'h70;
  localparam logic [7:0] RCL_T1_ONES = 8'h0e;
  // ==========================================
  // carriers and states
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } lsi_port_t;
  typedef struct packed {
    logic loop_up_detected;
    logic loop_down_detected;
    logic current_limit_exceeded;
    logic transmit_open_detected;
    logic prbs_lock_detected;
  } lsi_line_t;
  typedef enum logic [1:0] {
    RCL_CLEAR = 2'b00,
    RCL_LOST = 2'b01,
    RCL_WINDOW = 2'b11
  } lsi_rcl_state_t;
endpackage

/* lsi_status_interrupt.sv */
// line status register, interrupt mask and active low interrupt output
// assumes a register port with one-cycle wr/rd strobes on the core clock
// and status sources on the same clock, except the transmit clock pin
//
// Operation
// - latched bit pends on its event, sets at a status write of one, holds until read, read clears it
// - cleared latched bit sets again only on a new occurrence
// - all ones and carrier loss bits survive a read while alarm persists
// - status write: ones refresh with current status, zeros keep old value
// - each status bit reaches interrupt only when same mask bit is one
// - carrier loss, all ones, clock loss interrupt on every change of state
// - change interrupts release on a status read once the last status write named the causing bit
// - other bits interrupt when set, release on a status read after a status write naming the causing bit
// - e1 all ones: set under two zeros, clear over two, per 512 bits
// - t1 all ones: set at five zeros or fewer, clear at six, per 3 ms
// - e1 carrier loss: 255 or 2048 zeros set, 32 ones in 255 clear
// - t1 carrier loss: 192 or 1544 zeros set, 14 ones in 112 clear
// - bit 7 latches when the loop-up code is received
// - bit 6 latches when the loop-down code is received
// - bit 5 live: transmit clock idle 5 us, also drives loss output
// - bit 4 latches on unframed all ones for the current mode
// - bit 3 latches on carrier loss for the current mode
// - bit 2 live: transmit current limiter active, enabled or not
// - bit 1 live: transmit outputs open circuited
// - bit 0 live: receiver locked on the pseudo-random sequence
`timescale 1ns/1ps
module lsi_status_interrupt #(
  parameter int unsigned UA1_WIN_CYC = lsi_pkg::UA1_T1_WIN_CYC
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire lsi_pkg::lsi_port_t i_port,
  output logic [7:0] o_rdata,
  input wire logic i_line_bit_en,
  input wire logic i_line_bit,
  input wire logic i_e1_mode,
  input wire logic i_long_los,
  input wire lsi_pkg::lsi_line_t i_line,
  input wire logic i_transmit_clock_in,
  output logic o_transmit_clock_lost,
  output logic o_int_n
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  // ==========================================
  // transmit clock supervision
  logic tck_s1_q;
  logic tck_s2_q;
  logic tck_s3_q;
  logic tck_f_q;
  logic tck_toggle;
  logic [9:0] transmit_clock_lost_cnt_q;
  logic transmit_clock_lost_q;

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      tck_s1_q <= 1'b0;
      tck_s2_q <= 1'b0;
      tck_s3_q <= 1'b0;
    end
    else
    begin
      tck_s1_q <= i_transmit_clock_in;
      tck_s2_q <= tck_s1_q;
      tck_s3_q <= tck_s2_q;
    end
  end

  // a level counts only once the last two stages agree
  assign tck_toggle = (tck_s2_q == tck_s3_q) && (tck_s2_q != tck_f_q);

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      tck_f_q <= 1'b0;
    else if (tck_s2_q == tck_s3_q)
      tck_f_q <= tck_s2_q;
  end

  // nominal 5 us; a fixed count of 1000 core cycles, with the sync delay on top
  always_ff @(posedge i_clock)
  begin
    if (i_srst || tck_toggle)
    begin
      transmit_clock_lost_cnt_q <= 10'h000;
      transmit_clock_lost_q <= 1'b0;
    end
    else if (transmit_clock_lost_cnt_q != 10'(lsi_pkg::TRANSMIT_CLOCK_LOST_CYC - 1))
      transmit_clock_lost_cnt_q <= transmit_clock_lost_cnt_q + 10'h001;
    else
      transmit_clock_lost_q <= 1'b1;
  end
  assign o_transmit_clock_lost = transmit_clock_lost_q;

  // ==========================================
  // line alarms
  logic ua1_alarm;
  logic rcl_alarm;

  lsi_line_alarms #(
    .UA1_WIN_CYC(UA1_WIN_CYC)
  ) u_alarms (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_bit_en(i_line_bit_en),
    .i_bit(i_line_bit),
    .i_e1_mode(i_e1_mode),
    .i_long_los(i_long_los),
    .o_ua1_alarm(ua1_alarm),
    .o_rcl_alarm(rcl_alarm)
  );

  // ==========================================
  // live status vector and its edges
  logic [7:0] live;
  logic [7:0] prev_q;
  logic [7:0] rise;
  logic [7:0] change;

  assign live = {i_line.loop_up_detected,
                 i_line.loop_down_detected,
                 transmit_clock_lost_q,
                 ua1_alarm,
                 rcl_alarm,
                 i_line.current_limit_exceeded,
                 i_line.transmit_open_detected,
                 i_line.prbs_lock_detected};

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      prev_q <= lsi_pkg::STATUS_RESET;
    else
      prev_q <= live;
  end
  assign rise = live & ~prev_q;
  assign change = live ^ prev_q;

  // ==========================================
  // register port decode
  logic st_wr;
  logic st_rd;
  logic mk_wr;
  logic mk_rd;

  assign st_wr = i_port.wr && i_port.addr == lsi_pkg::ADDR_STATUS;
  assign st_rd = i_port.rd && i_port.addr == lsi_pkg::ADDR_STATUS;
  assign mk_wr = i_port.wr && i_port.addr == lsi_pkg::ADDR_MASK;
  assign mk_rd = i_port.rd && i_port.addr == lsi_pkg::ADDR_MASK;

  // ==========================================
  // pending occurrences of latched events
  logic [7:0] ev_set;
  logic [7:0] ev_q;
  logic [7:0] capture;

  assign ev_set = rise & lsi_pkg::LATCHED_BITS;
  assign capture = st_wr ? (i_port.wdata & lsi_pkg::LATCHED_BITS) : 8'h00;

  // a set in the capture cycle wins, so nothing slips past the host
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      ev_q <= lsi_pkg::STATUS_RESET;
    else
      ev_q <= (ev_q & ~capture) | ev_set;
  end

  // ==========================================
  // status register
  logic [7:0] fresh;
  logic [7:0] line_status_q;
  logic [7:0] sel_q;

  assign fresh = (lsi_pkg::LATCHED_BITS & (ev_q | ev_set | (live & lsi_pkg::STICKY_BITS)))
               | (~lsi_pkg::LATCHED_BITS & live);

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      line_status_q <= lsi_pkg::STATUS_RESET;
    else if (st_wr)
      line_status_q <= (i_port.wdata & fresh) | (~i_port.wdata & line_status_q);
    else if (st_rd)
      line_status_q <= (line_status_q & ~lsi_pkg::LATCHED_BITS)
                     | (line_status_q & live & lsi_pkg::STICKY_BITS);
  end

  // the bits named by the last status write are the ones a read acknowledges
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      sel_q <= lsi_pkg::STATUS_RESET;
    else if (st_wr)
      sel_q <= i_port.wdata;
  end

  // ==========================================
  // mask register and interrupt
  logic [7:0] interrupt_enable_mask_q;
  logic [7:0] irq_set;
  logic [7:0] irq_clr;
  logic [7:0] irq_q;
  logic int_n_q;

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      interrupt_enable_mask_q <= lsi_pkg::MASK_RESET;
    else if (mk_wr)
      interrupt_enable_mask_q <= i_port.wdata;
  end

  assign irq_set = (change & lsi_pkg::COS_BITS)
                 | (rise & ~lsi_pkg::COS_BITS);
  assign irq_clr = st_rd ? sel_q : 8'h00;

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      irq_q <= lsi_pkg::STATUS_RESET;
    else
      irq_q <= (irq_q & ~irq_clr) | irq_set;
  end

  // a masked source still pends, so unmasking later raises the line
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      int_n_q <= 1'b1;
    else
      int_n_q <= ~|(irq_q & interrupt_enable_mask_q);
  end
  assign o_int_n = int_n_q;

  // ==========================================
  // read data
  logic [7:0] rdata_q;

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      rdata_q <= lsi_pkg::RDATA_RESET;
    else if (st_rd)
      rdata_q <= line_status_q;
    else if (mk_rd)
      rdata_q <= interrupt_enable_mask_q;
    else if (i_port.rd)
      rdata_q <= lsi_pkg::RDATA_RESET;
  end
  assign o_rdata = rdata_q;

  // ==========================================
  // checks
  chk_transmit_clock_lost_timeout: assert property ($rose(transmit_clock_lost_q)
    |-> $past(transmit_clock_lost_cnt_q) == 10'(lsi_pkg::TRANSMIT_CLOCK_LOST_CYC - 1))
    else $error("clock loss raised at wrong count");
  chk_transmit_clock_lost_release: assert property (tck_toggle |=> !o_transmit_clock_lost)
    else $error("clock loss held after transmit clock edge");
  chk_write_refresh: assert property (st_wr && i_port.wdata[2]
    |=> line_status_q[2] == $past(live[2]))
    else $error("written one did not refresh status");
  chk_write_hold: assert property (st_wr && !i_port.wdata[1]
    |=> $stable(line_status_q[1]))
    else $error("written zero changed status");
  chk_read_clear: assert property (st_rd && !st_wr
    |=> line_status_q[7:6] == 2'b00)
    else $error("latched bits not cleared by read");
  chk_sticky_read: assert property (st_rd && !st_wr && line_status_q[4] && live[4]
    |=> line_status_q[4])
    else $error("all ones bit lost while alarm present");
  chk_event_pend: assert property (ev_set[6] |=> ev_q[6])
    else $error("latched event dropped");
  chk_cos_pend: assert property (change[3] |=> irq_q[3])
    else $error("carrier change raised no interrupt");
  chk_rd_release: assert property (st_rd && sel_q[0] && !irq_set[0]
    |=> !irq_q[0])
    else $error("read did not release interrupt source");
  chk_mask_gate: assert property ((irq_q & interrupt_enable_mask_q) == 8'h00
    |=> o_int_n)
    else $error("masked source drove interrupt");
  chk_int_assert: assert property (|(irq_q & interrupt_enable_mask_q)
    |=> !o_int_n)
    else $error("enabled pending source left interrupt high");
  chk_mask_read: assert property (mk_rd |=> o_rdata == $past(interrupt_enable_mask_q))
    else $error("mask read returned wrong value");
endmodule

/* lsi_status_interrupt_tb.sv */
// self-checking bench of the line status and interrupt block
// assumes the host model drives the register port; line sources come from here
`timescale 1ns/1ps
module lsi_status_interrupt_tb;
  logic i_clock;
  logic i_srst;
  logic i_line_bit_en;
  logic i_line_bit;
  logic i_transmit_clock_in;
  logic i_e1_mode;
  logic i_long_los;
  logic transmit_clock_in_run;
  lsi_pkg::lsi_line_t line_s;
  lsi_pkg::lsi_port_t port_s;
  logic [7:0] o_rdata;
  logic o_transmit_clock_lost;
  logic o_int_n;
  logic [7:0] v;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [4:0] row_line [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
  logic [7:0] row_mask [5] = '{8'h80, 8'h40, 8'h04, 8'h02, 8'h01};

  lsi_status_interrupt #(.UA1_WIN_CYC(64)) uut (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_port(port_s),
    .o_rdata(o_rdata),
    .i_line_bit_en(i_line_bit_en),
    .i_line_bit(i_line_bit),
    .i_e1_mode(i_e1_mode),
    .i_long_los(i_long_los),
    .i_line(line_s),
    .i_transmit_clock_in(i_transmit_clock_in),
    .o_transmit_clock_lost(o_transmit_clock_lost),
    .o_int_n(o_int_n)
  );

  lsi_host_model host (
    .i_clock(i_clock),
    .i_rdata(o_rdata),
    .o_port(port_s)
  );

  // ==========================================
  // clocks and helpers
  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // transmit clock runs unrelated to the core clock while enabled
  initial
  begin
    i_transmit_clock_in = 1'b0;
    #3;
    forever #324 if (transmit_clock_in_run) i_transmit_clock_in = ~i_transmit_clock_in;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic send_bits(input int n, input logic val);
    repeat (n)
    begin
      @(posedge i_clock);
      i_line_bit_en <= 1'b1;
      i_line_bit <= val;
    end
    @(posedge i_clock);
    i_line_bit_en <= 1'b0;
  endtask

  task automatic int_is(input logic exp);
    check("int_n", {7'h00, o_int_n}, {7'h00, exp});
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #300000;
    n_mismatch++;
    wrap_up();
  end

  // ==========================================
  // main sequence
  initial
  begin
    i_srst = 1'b1;
    i_line_bit_en = 1'b0;
    i_line_bit = 1'b1;
    i_e1_mode = 1'b1;
    i_long_los = 1'b0;
    transmit_clock_in_run = 1'b1;
    line_s = '0;
    cyc(20);
    i_srst <= 1'b0;
    cyc(1);
    int_is(1'b1);
    host.read_reg(lsi_pkg::ADDR_MASK, v);
    check("mask reset", v, lsi_pkg::MASK_RESET);
    $display("test reset done");

    for (int i = 0; i < 5; i++)
    begin
      host.write_reg(lsi_pkg::ADDR_MASK, row_mask[i]);
      line_s <= lsi_pkg::lsi_line_t'(row_line[i]);
      cyc(3);
      int_is(1'b0);
      host.write_reg(lsi_pkg::ADDR_STATUS, 8'h00);
      host.read_reg(lsi_pkg::ADDR_STATUS, v);
      check("status held", v & row_mask[i], 8'h00);
      int_is(1'b0);
      host.poll(row_mask[i], v);
      check("status set", v & row_mask[i], row_mask[i]);
      cyc(3);
      int_is(1'b1);
      line_s <= '0;
      cyc(3);
      int_is(1'b1);
      host.poll(row_mask[i], v);
      check("status cleared", v & row_mask[i], 8'h00);
    end
    $display("test source rows done");

    host.write_reg(lsi_pkg::ADDR_MASK, 8'h00);
    line_s <= lsi_pkg::lsi_line_t'(5'h04);
    cyc(3);
    int_is(1'b1);
    host.write_reg(lsi_pkg::ADDR_MASK, 8'h04);
    cyc(3);
    int_is(1'b0);
    host.poll(8'h04, v);
    line_s <= '0;
    cyc(3);
    int_is(1'b1);
    host.write_reg(lsi_pkg::ADDR_MASK, 8'h5a);
    host.write_reg(8'h08, 8'hff);
    host.read_reg(lsi_pkg::ADDR_MASK, v);
    check("mask rw", v, 8'h5a);
    host.read_reg(8'h05, v);
    check("unmapped", v, 8'h00);
    $display("test masking done");

    host.write_reg(lsi_pkg::ADDR_MASK, 8'h20);
    transmit_clock_in_run = 1'b0;
    cyc(1010);
    check("clock lost", {7'h00, o_transmit_clock_lost}, 8'h01);
    int_is(1'b0);
    host.poll(8'h20, v);
    check("clock lost bit", v & 8'h20, 8'h20);
    cyc(3);
    int_is(1'b1);
    transmit_clock_in_run = 1'b1;
    cyc(400);
    check("clock back", {7'h00, o_transmit_clock_lost}, 8'h00);
    int_is(1'b0);
    host.poll(8'h20, v);
    check("clock back bit", v & 8'h20, 8'h00);
    $display("test clock loss done");

    host.write_reg(lsi_pkg::ADDR_MASK, 8'h10);
    send_bits(511, 1'b1);
    cyc(4);
    int_is(1'b1);
    send_bits(1, 1'b1);
    cyc(4);
    int_is(1'b0);
    host.poll(8'h10, v);
    check("all ones bit", v & 8'h10, 8'h10);
    cyc(3);
    int_is(1'b1);
    send_bits(3, 1'b0);
    send_bits(509, 1'b1);
    cyc(4);
    int_is(1'b0);
    host.poll(8'h10, v);
    $display("test all ones done");

    host.write_reg(lsi_pkg::ADDR_MASK, 8'h08);
    cyc(3);
    int_is(1'b1);
    send_bits(254, 1'b0);
    cyc(4);
    int_is(1'b1);
    send_bits(1, 1'b0);
    cyc(4);
    int_is(1'b0);
    host.poll(8'h08, v);
    check("carrier bit", v & 8'h08, 8'h08);
    cyc(3);
    int_is(1'b1);
    host.read_reg(lsi_pkg::ADDR_STATUS, v);
    check("carrier kept", v & 8'h08, 8'h08);
    send_bits(255, 1'b1);
    cyc(4);
    int_is(1'b0);
    host.poll(8'h08, v);
    cyc(3);
    int_is(1'b1);
    $display("test carrier loss done");

    i_srst <= 1'b1;
    cyc(2);
    i_srst <= 1'b0;
    cyc(1);
    int_is(1'b1);
    host.read_reg(lsi_pkg::ADDR_MASK, v);
    check("mask reset again", v, lsi_pkg::MASK_RESET);
    host.read_reg(lsi_pkg::ADDR_STATUS, v);
    check("status reset", v, lsi_pkg::STATUS_RESET);
    $display("test second reset done");

    // t1 window is timed in core cycles, so an idle line raises the alarm
    i_e1_mode <= 1'b0;
    host.write_reg(lsi_pkg::ADDR_MASK, 8'h10);
    cyc(140);
    int_is(1'b0);
    // a run of zeros longer than two windows clears it; the long option keeps carrier
    i_long_los <= 1'b1;
    send_bits(200, 1'b0);
    cyc(1);
    check("t1 all ones clear", {7'h00, uut.ua1_alarm}, 8'h00);
    host.poll(8'h08, v);
    check("long zero run", v & 8'h08, 8'h00);
    $display("test t1 mode done");
    wrap_up();
  end
endmodule
